// ### common/cstsr_defines.svh
`ifndef CSTSR_DEFINES_SVH
`define CSTSR_DEFINES_SVH
// Overview of operation
// - Quadrature mode: binary data word reports the input counter value.
// - Total counts accumulates every input count; host may preload it.
// - Total counts cleared to zero at power-up.
// - Quadrature mode: home marker clears total counts to zero.
// - Quadrature mode: preload input leaves total counts unchanged.
// - A strobe event captures binary data into its own register while its latch is clear.
// - Inputs 9 to 12 are strobe channels 1 to 4.
// - Active capture edge of each strobe is configurable.
// - Timer 1 measures ms between input 10 edges, or input 10 to 9.
// - Timer 1 starts only when input 10 strobe latch is clear.
// - Gated strobe 2: timer 1 starts only if comparator 6 is on.
// - Gated strobe 1 stopping timer 1 needs comparator 5 on.
// - Timer 2 measures ms between input 12 edges by default.
// - Configured, timer 2 measures from input 12 to input 11 edges.
// - Timer 2 starts with input 12 latch clear; gated needs comparator 8.
// - Gated strobe 3 stopping timer 2 needs comparator 7 on.
// - 16-bit status word shows comparator outputs 17 to 32.
// - Host strobe reset clears latch; held, every strobe recaptures data.
// - Absolute mode: binary data word is Gray input converted to binary.
`define CSTSR_DATA_W 16
`define CSTSR_TOTAL_W 32
`define CSTSR_TIMER_W 16
`define CSTSR_NSTROBE 4
`define CSTSR_CLK_HZ 10000000
`define CSTSR_TICK_MS 1
`define CSTSR_TICK_CYC ((`CSTSR_CLK_HZ / 1000) * `CSTSR_TICK_MS)
`define CSTSR_TOTAL_RST 32'h0000_0000
`define CSTSR_TIMER_MAX 16'hffff
`define CSTSR_CMP_START1 5
`define CSTSR_CMP_STOP1 4
`define CSTSR_CMP_START2 7
`define CSTSR_CMP_STOP2 6
`endif

// ### common/cstsr_pkg.sv
package cstsr_pkg;
  typedef enum logic [1:0] {
    CSTSR_IDLE = 2'b00,
    CSTSR_RUN = 2'b01,
    CSTSR_DONE = 2'b10
  } cstsr_tmr_e;
endpackage

// ### common/cstsr_tmr_if.sv
`timescale 1ns/1ps
interface cstsr_tmr_if;
  logic start;
  logic stop;
  logic tick;
  logic [15:0] value;
  logic running;
  modport ctl (output start, output stop, output tick, input value, input running);
  modport tmr (input start, input stop, input tick, output value, output running);
endinterface

// ### hdl/cstsr_interval_timer.sv
`timescale 1ns/1ps
`include "cstsr_defines.svh"
module cstsr_interval_timer #(
  parameter int TW = `CSTSR_TIMER_W
) (
  input wire logic core_clk,
  input wire logic rst,
  cstsr_tmr_if.tmr bus
);
  cstsr_pkg::cstsr_tmr_e state_q;
  logic [TW-1:0] cnt_q;
  logic sat;
  assign sat = (cnt_q == {TW{1'b1}});
  assign bus.value = cnt_q;
  assign bus.running = (state_q == cstsr_pkg::CSTSR_RUN);
  // ---------------------------------------
  // Start/stop counting
  // ---------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= cstsr_pkg::CSTSR_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        cstsr_pkg::CSTSR_IDLE, cstsr_pkg::CSTSR_DONE: begin
          if (bus.start) begin
            state_q <= cstsr_pkg::CSTSR_RUN;
            cnt_q <= '0;
          end
        end
        cstsr_pkg::CSTSR_RUN: begin
          if (bus.stop) begin
            state_q <= cstsr_pkg::CSTSR_DONE;
          end else if (bus.tick && !sat) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: state_q <= cstsr_pkg::CSTSR_IDLE;
      endcase
    end
  end
  a_timer_saturate: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == cstsr_pkg::CSTSR_RUN && sat) |=> sat)
    else $error("Timer wrapped");
  a_timer_step: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == cstsr_pkg::CSTSR_RUN && !bus.stop && bus.tick && !sat)
    |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("Timer missed a tick");
endmodule

// ### hdl/cstsr_counter_strobe.sv
`timescale 1ns/1ps
`include "cstsr_defines.svh"
module cstsr_counter_strobe #(
  parameter int DW = `CSTSR_DATA_W,
  parameter int TOTW = `CSTSR_TOTAL_W,
  parameter int TICK_CYC = `CSTSR_TICK_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic quadrature_counting_mode,
  input wire logic absolute_position_mode,
  input wire logic [DW-1:0] counter_value,
  input wire logic [DW-1:0] gray_input,
  input wire logic count_inc,
  input wire logic count_dec,
  input wire logic home_marker,
  input wire logic preload_input,
  input wire logic total_load,
  input wire logic [TOTW-1:0] total_load_value,
  input wire logic [3:0] strobe_in,
  input wire logic [3:0] strobe_edge_fall,
  input wire logic [3:0] comparator_gated_strobe_setting,
  input wire logic [3:0] strobe_reset,
  input wire logic timer1_two_input,
  input wire logic timer2_two_input,
  input wire logic [15:0] range_compare_low,
  input wire logic [15:0] range_compare_upper_in,
  output logic [DW-1:0] binary_data,
  output logic [TOTW-1:0] total_counts,
  output logic [4*DW-1:0] strobe_data,
  output logic [3:0] strobe_latch,
  output logic [15:0] timer1_ms,
  output logic [15:0] timer2_ms,
  output logic [15:0] range_compare_upper_status
);
  // ---------------------------------------
  // Binary data word
  // ---------------------------------------
  logic [DW-1:0] gray_bin;
  logic [DW-1:0] binary_d;
  logic [DW-1:0] binary_q;
  genvar gi;
  assign gray_bin[DW-1] = gray_input[DW-1];
  generate
    for (gi = 0; gi < DW - 1; gi++) begin : g_gray
      assign gray_bin[gi] = gray_bin[gi+1] ^ gray_input[gi];
    end
  endgenerate
  assign binary_d = quadrature_counting_mode ? counter_value :
    (absolute_position_mode ? gray_bin : binary_q);
  always_ff @(posedge core_clk) begin
    if (rst) binary_q <= '0;
    else binary_q <= binary_d;
  end
  assign binary_data = binary_q;
  // ---------------------------------------
  // Total counts
  // ---------------------------------------
  logic [TOTW-1:0] total_q;
  logic [TOTW-1:0] total_d;
  logic home_clr;
  logic total_ignores_preload;
  assign home_clr = quadrature_counting_mode && home_marker;
  // Preload input has no path into total counts in quadrature mode
  assign total_ignores_preload = quadrature_counting_mode && preload_input;
  assign total_d = home_clr ? '0 :
    total_load ? total_load_value :
    (count_inc && !count_dec) ? total_q + 1'b1 :
    (count_dec && !count_inc) ? total_q - 1'b1 : total_q;
  always_ff @(posedge core_clk) begin
    if (rst) total_q <= `CSTSR_TOTAL_RST;
    else total_q <= total_d;
  end
  assign total_counts = total_q;
  // ---------------------------------------
  // Strobe sync, edge detect, capture
  // ---------------------------------------
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] stb_ev;
  logic [3:0] stb_gate;
  logic [3:0] latch_q;
  logic [DW-1:0] cap_q [4];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= strobe_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  generate
    for (gi = 0; gi < 4; gi++) begin : g_stb
      assign stb_ev[gi] = strobe_edge_fall[gi] ? (s3_q[gi] && !s2_q[gi]) :
        (!s3_q[gi] && s2_q[gi]);
      assign stb_gate[gi] = !comparator_gated_strobe_setting[gi] || range_compare_low[gi+4];
      always_ff @(posedge core_clk) begin
        if (rst) begin
          latch_q[gi] <= 1'b0;
          cap_q[gi] <= '0;
        end else begin
          if (stb_ev[gi] && (!latch_q[gi] || strobe_reset[gi])) begin
            cap_q[gi] <= binary_q;
          end
          if (strobe_reset[gi]) latch_q[gi] <= 1'b0;
          else if (stb_ev[gi]) latch_q[gi] <= 1'b1;
        end
      end
      assign strobe_data[gi*DW +: DW] = cap_q[gi];
    end
  endgenerate
  assign strobe_latch = latch_q;
  // ---------------------------------------
  // Millisecond tick
  // ---------------------------------------
  logic [15:0] div_q;
  logic tick_q;
  logic div_end;
  assign div_end = (div_q == 16'(TICK_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_end ? '0 : div_q + 1'b1;
      tick_q <= div_end;
    end
  end
  // ---------------------------------------
  // Interval timers
  // ---------------------------------------
  cstsr_tmr_if t1_if ();
  cstsr_tmr_if t2_if ();
  logic t1_ok;
  logic t2_ok;
  logic t1_stop9;
  logic t2_stop11;
  logic t1_stop10;
  logic t2_stop12;
  assign t1_ok = stb_ev[1] && !latch_q[1] && stb_gate[1];
  assign t2_ok = stb_ev[3] && !latch_q[3] && stb_gate[3];
  assign t1_stop9 = stb_ev[0] && stb_gate[0];
  assign t2_stop11 = stb_ev[2] && stb_gate[2];
  // Default: input 10 edge starts and stops; the latch only guards the start
  assign t1_stop10 = stb_ev[1] && stb_gate[1];
  assign t2_stop12 = stb_ev[3] && stb_gate[3];
  assign t1_if.start = t1_ok && !(t1_if.running && !timer1_two_input);
  assign t1_if.stop = timer1_two_input ? t1_stop9 : t1_stop10;
  assign t1_if.tick = tick_q;
  assign t2_if.start = t2_ok && !(t2_if.running && !timer2_two_input);
  assign t2_if.stop = timer2_two_input ? t2_stop11 : t2_stop12;
  assign t2_if.tick = tick_q;
  cstsr_interval_timer u_t1 (
    .core_clk(core_clk),
    .rst(rst),
    .bus(t1_if.tmr)
  );
  cstsr_interval_timer u_t2 (
    .core_clk(core_clk),
    .rst(rst),
    .bus(t2_if.tmr)
  );
  logic [15:0] t1_q;
  logic [15:0] t2_q;
  logic [15:0] rc_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      t1_q <= '0;
      t2_q <= '0;
      rc_q <= '0;
    end else begin
      t1_q <= t1_if.value;
      t2_q <= t2_if.value;
      rc_q <= range_compare_upper_in;
    end
  end
  assign timer1_ms = t1_q;
  assign timer2_ms = t2_q;
  assign range_compare_upper_status = rc_q;
  // ---------------------------------------
  // Assertions
  // ---------------------------------------
  a_power_clear: assert property (@(posedge core_clk)
    rst |=> total_q == '0)
    else $error("Total not cleared at reset");
  a_home_clear: assert property (@(posedge core_clk) disable iff (rst)
    home_clr |=> total_q == '0)
    else $error("Home marker did not clear total");
  a_preload_hold: assert property (@(posedge core_clk) disable iff (rst)
    (total_ignores_preload && !home_marker && !total_load && !count_inc && !count_dec)
    |=> $stable(total_q))
    else $error("Preload input changed total");
  a_host_load: assert property (@(posedge core_clk) disable iff (rst)
    (total_load && !home_clr) |=> total_q == $past(total_load_value))
    else $error("Host preload not taken");
  a_count_up: assert property (@(posedge core_clk) disable iff (rst)
    (!home_clr && !total_load && count_inc && !count_dec)
    |=> total_q == $past(total_q) + 1'b1)
    else $error("Total did not count up");
  a_count_down: assert property (@(posedge core_clk) disable iff (rst)
    (!home_clr && !total_load && count_dec && !count_inc)
    |=> total_q == $past(total_q) - 1'b1)
    else $error("Total did not count down");
  a_quad_data: assert property (@(posedge core_clk) disable iff (rst)
    quadrature_counting_mode |=> binary_q == $past(counter_value))
    else $error("Binary word not the counter value");
  a_gray_data: assert property (@(posedge core_clk) disable iff (rst)
    (!quadrature_counting_mode && absolute_position_mode)
    |=> (binary_q ^ (binary_q >> 1)) == $past(gray_input))
    else $error("Binary word not the decoded encoder value");
  a_strobe_cap: assert property (@(posedge core_clk) disable iff (rst)
    (stb_ev[0] && strobe_reset[0]) |=> cap_q[0] == $past(binary_q))
    else $error("Strobe 1 data not captured");
  a_reset_latch: assert property (@(posedge core_clk) disable iff (rst)
    strobe_reset[2] |=> !latch_q[2])
    else $error("Strobe latch not cleared");
  a_gate_start: assert property (@(posedge core_clk) disable iff (rst)
    (comparator_gated_strobe_setting[1] && !range_compare_low[`CSTSR_CMP_START1] && !t1_if.running)
    |=> !t1_if.running)
    else $error("Timer 1 started without comparator 6");
  a_t1_latch: assert property (@(posedge core_clk) disable iff (rst)
    (latch_q[1] && !t1_if.running) |=> !t1_if.running)
    else $error("Timer 1 started with latch set");
  a_t1_edge_stop: assert property (@(posedge core_clk) disable iff (rst)
    (!timer1_two_input && t1_if.running && stb_ev[1]
      && (!comparator_gated_strobe_setting[1] || range_compare_low[`CSTSR_CMP_START1]))
    |=> !t1_if.running)
    else $error("Timer 1 not stopped by input 10");
  a_t1_hold9: assert property (@(posedge core_clk) disable iff (rst)
    (timer1_two_input && t1_if.running && stb_ev[0]
      && comparator_gated_strobe_setting[0] && !range_compare_low[`CSTSR_CMP_STOP1])
    |=> t1_if.running)
    else $error("Timer 1 stopped without comparator 5");
  a_latch_start: assert property (@(posedge core_clk) disable iff (rst)
    (latch_q[3] && !t2_if.running) |=> !t2_if.running)
    else $error("Timer 2 started with latch set");
  a_t2_gate: assert property (@(posedge core_clk) disable iff (rst)
    (comparator_gated_strobe_setting[3] && !range_compare_low[`CSTSR_CMP_START2] && !t2_if.running)
    |=> !t2_if.running)
    else $error("Timer 2 started without comparator 8");
  a_t2_edge_stop: assert property (@(posedge core_clk) disable iff (rst)
    (!timer2_two_input && t2_if.running && stb_ev[3]
      && (!comparator_gated_strobe_setting[3] || range_compare_low[`CSTSR_CMP_START2]))
    |=> !t2_if.running)
    else $error("Timer 2 not stopped by input 12");
  a_t2_hold11: assert property (@(posedge core_clk) disable iff (rst)
    (timer2_two_input && t2_if.running && stb_ev[2]
      && comparator_gated_strobe_setting[2] && !range_compare_low[`CSTSR_CMP_STOP2])
    |=> t2_if.running)
    else $error("Timer 2 stopped without comparator 7");
  a_status_copy: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> rc_q == $past(range_compare_upper_in))
    else $error("Comparator status word not updated");
  a_tick_period: assert property (@(posedge core_clk) disable iff (rst)
    tick_q |=> !tick_q [*2])
    else $error("Tick too frequent");
  a_sync_delay: assert property (@(posedge core_clk) disable iff (rst)
    (!strobe_edge_fall[0] && $rose(strobe_in[0])) |-> ##2 stb_ev[0])
    else $error("Strobe edge not seen after sync");
  generate
    for (gi = 0; gi < 4; gi++) begin : g_stb_chk
      a_latch_set: assert property (@(posedge core_clk) disable iff (rst)
        (stb_ev[gi] && !strobe_reset[gi]) |=> latch_q[gi])
        else $error("Strobe latch not set");
      a_latch_hold: assert property (@(posedge core_clk) disable iff (rst)
        (stb_ev[gi] && latch_q[gi] && !strobe_reset[gi]) |=> $stable(cap_q[gi]))
        else $error("Latched strobe overwrote its data");
      a_fall_sync: assert property (@(posedge core_clk) disable iff (rst)
        (strobe_edge_fall[gi] && $fell(strobe_in[gi])) |-> ##2 stb_ev[gi])
        else $error("Falling strobe edge not seen after sync");
    end
  endgenerate
  c_t1_run: cover property (@(posedge core_clk) t1_if.start ##[1:50] t1_if.stop);
  c_t2_run: cover property (@(posedge core_clk) t2_if.start ##[1:50] t2_if.stop);
  c_home: cover property (@(posedge core_clk) home_clr);
  c_recap: cover property (@(posedge core_clk) stb_ev[1] && latch_q[1] && strobe_reset[1]);
  c_t2_refused: cover property (@(posedge core_clk) stb_ev[3] && latch_q[3] && !strobe_reset[3]);
endmodule

// ### bench/cstsr_host_model.sv
`timescale 1ns/1ps
module cstsr_host_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load_req,
  input wire logic [31:0] load_word,
  input wire logic [3:0] latch_clr,
  output logic total_load,
  output logic [31:0] total_load_value,
  output logic [3:0] strobe_reset
);
  // ----------------------------------------
  // Command words registered on every clock, one cycle after the request
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      total_load <= 1'b0;
      total_load_value <= 32'h0000_0000;
      strobe_reset <= 4'h0;
    end else begin
      total_load <= load_req;
      total_load_value <= load_req ? load_word : ~total_load_value;
      strobe_reset <= latch_clr;
    end
  end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic core_clk = 1'b0, rst = 1'b1, quadrature_counting_mode = 1'b1, absolute_position_mode = 1'b0;
  logic count_inc = 1'b0, count_dec = 1'b0, home_marker = 1'b0, preload_input = 1'b0, load_req = 1'b0;
  logic timer1_two_input = 1'b0, timer2_two_input = 1'b0, total_load;
  logic [15:0] counter_value = 16'h0000, gray_input = 16'h0000, range_compare_low = 16'h0000;
  logic [15:0] range_compare_upper_in = 16'h0000, binary_data, timer1_ms, timer2_ms, range_compare_upper_status;
  logic [31:0] load_word = 32'h0000_0000, total_load_value, total_counts;
  logic [3:0] strobe_in = 4'h0, strobe_edge_fall = 4'h0, comparator_gated_strobe_setting = 4'h0;
  logic [3:0] latch_clr = 4'h0, strobe_reset, strobe_latch;
  logic [63:0] strobe_data;
  int miscompares = 0;
  int n_tests = 0;
  // ----------------------------------------
  // Device and host
  // ----------------------------------------
  cstsr_counter_strobe #(.TICK_CYC(10)) DUT (.core_clk, .rst, .quadrature_counting_mode, .absolute_position_mode,
    .counter_value, .gray_input, .count_inc, .count_dec, .home_marker, .preload_input, .total_load,
    .total_load_value, .strobe_in, .strobe_edge_fall, .comparator_gated_strobe_setting, .strobe_reset,
    .timer1_two_input, .timer2_two_input, .range_compare_low, .range_compare_upper_in, .binary_data,
    .total_counts, .strobe_data, .strobe_latch, .timer1_ms, .timer2_ms, .range_compare_upper_status);
  cstsr_host_model host (.core_clk, .rst, .load_req, .load_word, .latch_clr, .total_load, .total_load_value,
    .strobe_reset);
  initial forever #50 core_clk = ~core_clk;
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task test_done;
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task do_reset;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
  endtask
  task pulse(input int n);
    strobe_in[n] <= 1'b1;
    cyc(4);
    strobe_in[n] <= 1'b0;
    cyc(6);
  endtask
  task t_total;
    `CHK("total", 32'h0000_0000, total_counts)
    count_inc <= 1'b1;
    cyc(3);
    count_inc <= 1'b0;
    count_dec <= 1'b1;
    cyc(1);
    count_dec <= 1'b0;
    cyc(2);
    `CHK("total", 32'h0000_0002, total_counts)
    load_req <= 1'b1;
    load_word <= 32'h89ab_cdef;
    cyc(1);
    load_req <= 1'b0;
    cyc(3);
    `CHK("total", 32'h89ab_cdef, total_counts)
    preload_input <= 1'b1;
    cyc(3);
    `CHK("total", 32'h89ab_cdef, total_counts)
    preload_input <= 1'b0;
    home_marker <= 1'b1;
    cyc(1);
    home_marker <= 1'b0;
    cyc(2);
    `CHK("total", 32'h0000_0000, total_counts)
  endtask
  task t_data;
    counter_value <= 16'h00a5;
    cyc(3);
    `CHK("binary", 16'h00a5, binary_data)
    quadrature_counting_mode <= 1'b0;
    absolute_position_mode <= 1'b1;
    gray_input <= 16'hb3c7 ^ (16'hb3c7 >> 1);
    range_compare_upper_in <= 16'h5a3c;
    cyc(3);
    `CHK("binary", 16'hb3c7, binary_data)
    `CHK("status", 16'h5a3c, range_compare_upper_status)
  endtask
  task t_strobe;
    for (int n = 0; n < 4; n++) begin
      pulse(n);
      `CHK("sdata", 16'hb3c7, strobe_data[16*n +: 16])
      `CHK("latch", 1'b1, strobe_latch[n])
    end
    gray_input <= 16'h0f0f ^ (16'h0f0f >> 1);
    pulse(0);
    `CHK("sdata", 16'hb3c7, strobe_data[15:0])
    latch_clr <= 4'hf;
    cyc(4);
    `CHK("latch", 4'h0, strobe_latch)
    pulse(0);
    `CHK("sdata", 16'h0f0f, strobe_data[15:0])
    `CHK("latch", 4'h0, strobe_latch)
    strobe_edge_fall <= 4'h4;
    cyc(8);
    strobe_in[2] <= 1'b1;
    cyc(8);
    `CHK("sdata", 16'hb3c7, strobe_data[47:32])
    strobe_in[2] <= 1'b0;
    cyc(8);
    `CHK("sdata", 16'h0f0f, strobe_data[47:32])
  endtask
  task t_latch_gate;
    logic [15:0] v;
    latch_clr <= 4'h0;
    timer1_two_input <= 1'b1;
    do_reset;
    pulse(1);
    pulse(0);
    cyc(4);
    v = timer1_ms;
    pulse(1);
    cyc(40);
    `CHK("timer1", v, timer1_ms)
    timer1_two_input <= 1'b0;
    do_reset;
    pulse(1);
    pulse(3);
    cyc(40);
    pulse(1);
    pulse(3);
    cyc(4);
    `CHK("timer1_in_range", 1'b1, timer1_ms >= 16'h0005 && timer1_ms <= 16'h0007)
    `CHK("timer2_in_range", 1'b1, timer2_ms >= 16'h0005 && timer2_ms <= 16'h0007)
    v = timer2_ms;
    pulse(3);
    cyc(40);
    `CHK("timer2", v, timer2_ms)
    latch_clr <= 4'hf;
  endtask
  task t_timer(input int sel, input int a, input int b, input int post, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] v;
    do_reset;
    pulse(a);
    cyc(50);
    pulse(b);
    cyc(post);
    v = sel ? timer2_ms : timer1_ms;
    `CHK("timer_in_range", 1'b1, v >= lo && v <= hi)
  endtask
  initial begin
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    t_total;
    t_data;
    t_strobe;
    t_latch_gate;
    t_timer(0, 1, 1, 4, 16'h0005, 16'h0007);
    t_timer(1, 3, 3, 4, 16'h0005, 16'h0007);
    comparator_gated_strobe_setting <= 4'hf;
    t_timer(0, 1, 1, 4, 16'h0000, 16'h0000);
    t_timer(1, 3, 3, 4, 16'h0000, 16'h0000);
    timer1_two_input <= 1'b1;
    timer2_two_input <= 1'b1;
    range_compare_low <= 16'h00a0;
    t_timer(0, 1, 0, 100, 16'h000f, 16'h0012);
    t_timer(1, 3, 2, 100, 16'h000f, 16'h0012);
    range_compare_low <= 16'h00f0;
    t_timer(0, 1, 0, 100, 16'h0005, 16'h0007);
    t_timer(1, 3, 2, 100, 16'h0005, 16'h0007);
    test_done;
  end
  initial begin
    cyc(100000);
    miscompares++;
    test_done;
  end
endmodule
